// ### core/adcseq_apb.sv
/*
  APB slave front end: one access cycle, registered answer.
  Assumes the register side decodes reads combinationally.
*/
`timescale 1ns/1ps
`default_nettype none
module adcseq_apb (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  adcseq_if.bus regs
);
  logic setup;

  // Setup phase detect; answer comes in the first access cycle
  assign setup = psel_i & ~penable_i;
  assign regs.addr = paddr_i;
  assign regs.wdata = pwdata_i;
  assign regs.wr = psel_i & penable_i & pwrite_i & pready_o;

  // Answer registers, loaded during setup
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= setup;
      pslverr_o <= setup & regs.err;
      if (setup) begin
        prdata_o <= pwrite_i ? 32'h0 : regs.rdata;
      end
    end
  end
endmodule : adcseq_apb
`default_nettype wire

// ### core/adcseq_cnt.sv
/*
  Down counter for the sample time.
  Assumes load is a single-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module adcseq_cnt #(
  parameter int W = 8
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  output logic expired_o
);
  logic [W-1:0] cnt_q;

  // Load, then count down to zero and stay there
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= value_i;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign expired_o = (cnt_q == '0);
endmodule : adcseq_cnt
`default_nettype wire

// ### core/adcseq_consts.svh
/*
  Offsets, field positions, reset values and codes of the converter
  sequencer. Assumes a 12-bit APB byte address and 32-bit data.
*/
// Overview of operation
// - Stop-on-first-interrupt set: halt at first interrupt, hardware clears auto start.
// - Stop-on-first-interrupt clear: with auto start set, sequences keep running, overwriting old results.
// - Bit 3 of the control register always reads zero.
// - Auto start set: sampling restarts itself right after a conversion ends.
// - Auto start clear: only a software write of one starts sampling.
// - Sample enable reads one while acquiring, zero while holding.
// - Manual trigger source: writing zero to sample enable starts conversion.
// - Nonzero trigger source: hardware ends sampling and starts conversion.
// - Done flag set by hardware when a conversion ends; zero otherwise.
// - Clearing done never disturbs sampling or conversion under way.
// - Hardware clears done when each new conversion starts.
`ifndef ADCSEQ_CONSTS_SVH
`define ADCSEQ_CONSTS_SVH
`define ADCSEQ_CTRL_OFF 12'h000
`define ADCSEQ_STAT_OFF 12'h004
`define ADCSEQ_MASK_OFF 12'h008
`define ADCSEQ_SAMPT_OFF 12'h00c
`define ADCSEQ_DONE_BIT 0
`define ADCSEQ_SMPEN_BIT 1
`define ADCSEQ_AUTO_BIT 2
`define ADCSEQ_STOP_BIT 4
`define ADCSEQ_SRC_LSB 5
`define ADCSEQ_SRC_MSB 7
`define ADCSEQ_ON_BIT 15
`define ADCSEQ_SRC_MANUAL 3'h0
`define ADCSEQ_SRC_COUNT 3'h7
`define ADCSEQ_EV_CONV 0
`define ADCSEQ_EV_STOP 1
`define ADCSEQ_SAMPT_RST 8'h0f
`endif

// ### core/adcseq_if.sv
/*
  Register access carrier between the APB slave and the sequencer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface adcseq_if;
  logic wr;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic err;
  modport bus (output wr, addr, wdata, input rdata, err);
  modport core (input wr, addr, wdata, output rdata, err);
endinterface : adcseq_if
`default_nettype wire

// ### core/adcseq_pkg.sv
/*
  Types of the converter sequencer.
  Assumes nothing of its surroundings.
*/
package adcseq_pkg;
  // Sequencer states, Gray coded along idle, sample, convert
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b11
  } adcseq_state_e;
endpackage : adcseq_pkg

// ### core/adcseq_top.sv
/*
  Sample-then-convert sequencer of an analog-to-digital converter,
  with its control, status, mask and sample-time registers on APB.
  Assumes an external converter core that takes a start pulse and
  answers with a done level or pulse, and a hardware trigger pin,
  both asynchronous to clock_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_consts.svh"
module adcseq_top (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  input wire logic trig_i,
  input wire logic conv_done_i,
  output logic sample_o,
  output logic conv_start_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------

  adcseq_if regs ();

  adcseq_pkg::adcseq_state_e state_q;
  adcseq_pkg::adcseq_state_e state_d;

  logic on_q;
  logic [2:0] src_q;
  logic stop_q;
  logic auto_q;
  logic done_q;
  logic [1:0] stat_q;
  logic [1:0] stat_d;
  logic [1:0] mask_q;
  logic [7:0] sampt_q;
  logic sample_q;
  logic conv_start_q;
  logic irq_q;

  logic [1:0] trig_sync_q;
  logic trig_old_q;
  logic [1:0] done_sync_q;
  logic done_old_q;

  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic wr_sampt;
  logic trig_edge;
  logic conv_fin;
  logic sw_start;
  logic sw_end;
  logic hw_end;
  logic stop_hit;
  logic conv_begin;
  logic sample_enable_begin;
  logic cnt_expired;
  logic [1:0] events;

  // ---------------------------------------------------------------
  // Bus slave and sample timer
  // ---------------------------------------------------------------

  // APB front end, answers in the first access cycle
  adcseq_apb u_apb (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .pready_o(pready_o),
    .prdata_o(prdata_o),
    .pslverr_o(pslverr_o),
    .regs(regs.bus)
  );

  // Sample time counter for the counted trigger source
  adcseq_cnt #(
    .W(8)
  ) u_cnt (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .load_i(sample_enable_begin),
    .value_i(sampt_q),
    .expired_o(cnt_expired)
  );

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------

  // Two sync flops and one delay flop per pin; edge detect reads the second stage and the delay flop
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trig_sync_q <= 2'h0;
      trig_old_q <= 1'b0;
      done_sync_q <= 2'h0;
      done_old_q <= 1'b0;
    end else begin
      trig_sync_q <= {trig_sync_q[0], trig_i};
      trig_old_q <= trig_sync_q[1];
      done_sync_q <= {done_sync_q[0], conv_done_i};
      done_old_q <= done_sync_q[1];
    end
  end

  assign trig_edge = trig_sync_q[1] & ~trig_old_q;

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------

  // Write strobes, valid only at the accepting access edge
  assign wr_ctrl = regs.wr && (regs.addr == `ADCSEQ_CTRL_OFF);
  assign wr_stat = regs.wr && (regs.addr == `ADCSEQ_STAT_OFF);
  assign wr_mask = regs.wr && (regs.addr == `ADCSEQ_MASK_OFF);
  assign wr_sampt = regs.wr && (regs.addr == `ADCSEQ_SAMPT_OFF);

  // Read mux; unmapped offsets read zero and flag an error
  always_comb begin
    regs.rdata = 32'h0;
    regs.err = 1'b0;
    case (regs.addr)
      `ADCSEQ_CTRL_OFF: begin
        regs.rdata[`ADCSEQ_ON_BIT] = on_q;
        regs.rdata[`ADCSEQ_SRC_MSB:`ADCSEQ_SRC_LSB] = src_q;
        regs.rdata[`ADCSEQ_STOP_BIT] = stop_q;
        // Bit 3 is left at zero
        regs.rdata[`ADCSEQ_AUTO_BIT] = auto_q;
        // Sample enable mirrors the acquire phase
        regs.rdata[`ADCSEQ_SMPEN_BIT] = (state_q ==
                                         adcseq_pkg::ST_SAMPLE);
        regs.rdata[`ADCSEQ_DONE_BIT] = done_q;
      end
      `ADCSEQ_STAT_OFF: begin
        regs.rdata[1:0] = stat_q;
      end
      `ADCSEQ_MASK_OFF: begin
        regs.rdata[1:0] = mask_q;
      end
      `ADCSEQ_SAMPT_OFF: begin
        regs.rdata[7:0] = sampt_q;
      end
      default: begin
        regs.err = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Sequence events
  // ---------------------------------------------------------------

  // Software start only counts while auto start is off
  assign sw_start = wr_ctrl & regs.wdata[`ADCSEQ_SMPEN_BIT] & ~auto_q;

  // Writing zero to sample enable ends sampling, manual source
  assign sw_end = wr_ctrl & ~regs.wdata[`ADCSEQ_SMPEN_BIT] &
                  (src_q == `ADCSEQ_SRC_MANUAL);

  // Any other source ends sampling by hardware
  always_comb begin
    if (src_q == `ADCSEQ_SRC_MANUAL) begin
      hw_end = 1'b0;
    end else if (src_q == `ADCSEQ_SRC_COUNT) begin
      hw_end = cnt_expired;
    end else begin
      hw_end = trig_edge;
    end
  end

  // Converter answer ends the conversion
  assign conv_fin = (state_q == adcseq_pkg::ST_CONVERT) &
                    done_sync_q[1] & ~done_old_q;

  // First interrupt with stop selected halts the sequence
  assign stop_hit = conv_fin & stop_q;

  assign conv_begin = (state_d == adcseq_pkg::ST_CONVERT) &&
                      (state_q != adcseq_pkg::ST_CONVERT);
  assign sample_enable_begin = (state_d == adcseq_pkg::ST_SAMPLE) &&
                      (state_q != adcseq_pkg::ST_SAMPLE);

  // ---------------------------------------------------------------
  // Sequencer state machine
  // ---------------------------------------------------------------

  // Next state; disabling the module returns it to idle
  always_comb begin
    state_d = state_q;
    case (state_q)
      adcseq_pkg::ST_IDLE: begin
        if (on_q && (auto_q || sw_start)) begin
          state_d = adcseq_pkg::ST_SAMPLE;
        end
      end
      adcseq_pkg::ST_SAMPLE: begin
        if (!on_q) begin
          state_d = adcseq_pkg::ST_IDLE;
        end else if (sw_end || hw_end) begin
          state_d = adcseq_pkg::ST_CONVERT;
        end
      end
      adcseq_pkg::ST_CONVERT: begin
        if (!on_q) begin
          state_d = adcseq_pkg::ST_IDLE;
        end else if (conv_fin) begin
          if (stop_q) begin
            state_d = adcseq_pkg::ST_IDLE;
          end else if (auto_q) begin
            // Next sequence runs on, overwriting old results
            state_d = adcseq_pkg::ST_SAMPLE;
          end else begin
            state_d = adcseq_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        state_d = adcseq_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= adcseq_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------

  // Enable, trigger source and stop selection
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      on_q <= 1'b0;
      src_q <= `ADCSEQ_SRC_MANUAL;
      stop_q <= 1'b0;
    end else if (wr_ctrl) begin
      on_q <= regs.wdata[`ADCSEQ_ON_BIT];
      src_q <= regs.wdata[`ADCSEQ_SRC_MSB:`ADCSEQ_SRC_LSB];
      stop_q <= regs.wdata[`ADCSEQ_STOP_BIT];
    end
  end

  // Auto start; the hardware stop beats a same-cycle write
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      auto_q <= 1'b0;
    end else if (stop_hit) begin
      auto_q <= 1'b0;
    end else if (wr_ctrl) begin
      auto_q <= regs.wdata[`ADCSEQ_AUTO_BIT];
    end
  end

  // Done flag: hardware set wins over software clear
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      done_q <= 1'b0;
    end else if (conv_fin) begin
      done_q <= 1'b1;
    end else if (conv_begin) begin
      done_q <= 1'b0;
    end else if (wr_ctrl && !regs.wdata[`ADCSEQ_DONE_BIT]) begin
      // Only the flag changes; the sequence goes on
      done_q <= 1'b0;
    end
  end

  // Sample time for the counted trigger source
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sampt_q <= `ADCSEQ_SAMPT_RST;
    end else if (wr_sampt) begin
      sampt_q <= regs.wdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------

  // Conversion end and sequence stop events
  always_comb begin
    events = 2'h0;
    events[`ADCSEQ_EV_CONV] = conv_fin;
    events[`ADCSEQ_EV_STOP] = stop_hit;
  end

  // Write one to clear; a new event wins over the clear
  always_comb begin
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d = stat_q & ~regs.wdata[1:0];
    end
    stat_d = stat_d | events;
  end

  // Sticky status register
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stat_q <= 2'h0;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Mask register, one enables the event onto the interrupt
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mask_q <= 2'h0;
    end else if (wr_mask) begin
      mask_q <= regs.wdata[1:0];
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  // Sample-and-hold control and converter start pulse
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sample_q <= 1'b0;
      conv_start_q <= 1'b0;
    end else begin
      sample_q <= (state_d == adcseq_pkg::ST_SAMPLE);
      conv_start_q <= conv_begin;
    end
  end

  // Level interrupt, high while an unmasked status bit is set
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_d & mask_q);
    end
  end

  assign sample_o = sample_q;
  assign conv_start_o = conv_start_q;
  assign irq_o = irq_q;

endmodule : adcseq_top
`default_nettype wire

// ### tb/adcseq_sva.sv
/*
  Port checker of the converter sequencer.
  Assumes clock_i and resetn_i as on the top module.
*/
`timescale 1ns/1ps
`default_nettype none
module adcseq_sva (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  input wire logic trig_i,
  input wire logic conv_done_i,
  input wire logic sample_o,
  input wire logic conv_start_o,
  input wire logic irq_o
);
  // ----------------------------------------
  // Bus and sequencer relations
  // ----------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // Answer comes in the first access cycle only
  a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  a_ready_single: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access");
  a_err_unmapped: assert property (pready_o && paddr_i[11:4] != 0 |-> pslverr_o)
    else $error("unmapped access not refused");
  a_err_reads_zero: assert property (pslverr_o && !pwrite_i |-> prdata_o == 0)
    else $error("refused read not zero");
  a_gap_bit_zero: assert property (
    pready_o && !pwrite_i && paddr_i == 0 |-> !prdata_o[3])
    else $error("gap bit reads one");
  a_start_single: assert property (conv_start_o |=> !conv_start_o)
    else $error("start pulse too long");
  a_start_ends_sample: assert property (
    conv_start_o |-> $past(sample_o) && !sample_o)
    else $error("start without end of sampling");
  // Main scenarios reached
  c_start: cover property (conv_start_o);
  c_irq: cover property ($rose(irq_o));
  c_err: cover property (pslverr_o);
endmodule : adcseq_sva
bind adcseq_top adcseq_sva u_sva (.clock_i, .resetn_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .prdata_o, .pslverr_o, .trig_i,
  .conv_done_i, .sample_o, .conv_start_o, .irq_o);
`default_nettype wire

// ### tb/testbench.sv
/*
  Self-checking bench of the converter sequencer over APB.
  Assumes the top module and the checker bound to it.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  err_total++; $display("wrong value %s exp %h got %h", n, e, g); end end
module testbench;
  logic clock_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, r;
  logic pready_o, pslverr_o, trig_i = 0, conv_done_i = 0;
  logic sample_o, conv_start_o, irq_o, e;
  int err_total = 0, check_count = 0;
  localparam logic [31:0] ON = 32'h8000, AU = 32'h4, ST = 32'h10, SM = 32'h2;
  adcseq_top uut (.clock_i, .resetn_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .pready_o, .prdata_o, .pslverr_o, .trig_i,
    .conv_done_i, .sample_o, .conv_start_o, .irq_o);
  always #2 clock_i = ~clock_i;
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  // One APB transfer, held until ready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1;
    // No bound of its own; only the watchdog ends a hang in this wait
    do @(posedge clock_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] x, input string n);
    apb(0, a, 0);
    `CHK(n, x, r)
  endtask : rd
  function logic sig(input int k);
    return k == 0 ? conv_start_o : k == 1 ? sample_o : irq_o;
  endfunction : sig
  // Bounded wait for an output to go high
  task wt(input int k, input string n);
    for (int i = 0; i < 40 && sig(k) !== 1'b1; i++) @(posedge clock_i);
    `CHK(n, 1'b1, sig(k))
  endtask : wt
  // Pulse the trigger pin or the converter done
  task pls(input bit t);
    @(posedge clock_i);
    if (t) trig_i <= 1; else conv_done_i <= 1;
    repeat (3) @(posedge clock_i);
    trig_i <= 0;
    conv_done_i <= 0;
  endtask : pls
  task final_report;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  // Watchdog against a hang
  initial begin
    #40000;
    err_total++;
    final_report;
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clock_i);
    resetn_i <= 1;
    rd(12'h000, 0, "ctrl");
    rd(12'h004, 0, "status");
    rd(12'h008, 0, "mask");
    rd(12'h00c, 32'h0f, "stime");
    rd(12'h010, 0, "unmapped");
    `CHK("slverr", 1'b1, e)
    wr(12'h008, 32'h3);
    wr(12'h000, ON);
    wr(12'h000, ON | SM);
    wt(1, "manual sample");
    rd(12'h000, ON | SM, "sampling");
    wr(12'h000, ON);
    wt(0, "manual start");
    `CHK("hold", 1'b0, sample_o)
    rd(12'h000, ON, "done cleared");
    pls(0);
    wt(2, "irq");
    rd(12'h000, ON | 1, "done set");
    rd(12'h004, 1, "status conv");
    `CHK("no restart", 1'b0, sample_o)
    wr(12'h000, ON);
    rd(12'h000, ON, "done by zero");
    wr(12'h004, 1);
    repeat (2) @(posedge clock_i);
    `CHK("irq clear", 1'b0, irq_o)
    wr(12'h000, ON | AU | SM);
    wt(1, "auto sample");
    wr(12'h000, ON | AU);
    wt(0, "auto start");
    pls(0);
    wt(1, "auto restart");
    rd(12'h000, ON | AU | SM | 1, "auto done");
    wr(12'h000, ON | AU | SM);
    rd(12'h000, ON | AU | SM, "clear in run");
    `CHK("still sampling", 1'b1, sample_o)
    wr(12'h004, 3);
    wr(12'h000, ON | AU | ST | SM);
    wr(12'h000, ON | AU | ST);
    wt(0, "stop start");
    pls(0);
    repeat (3) @(posedge clock_i);
    `CHK("stopped", 1'b0, sample_o)
    rd(12'h000, ON | ST | 1, "auto cleared");
    rd(12'h004, 3, "status stop");
    wr(12'h004, 3);
    wr(12'h00c, 8);
    for (int s = 1; s < 8; s++) begin
      wr(12'h000, ON | (s << 5) | SM);
      wt(1, "src sample");
      if (s != 7) pls(1);
      wt(0, "src start");
      pls(0);
      wr(12'h004, 3);
    end
    // Trigger source with auto start: hardware alone clears done
    wr(12'h000, ON | 32'h20 | AU);
    wt(1, "trig auto sample");
    pls(1);
    wt(0, "trig auto start");
    pls(0);
    wt(1, "trig auto restart");
    rd(12'h000, ON | 32'h20 | AU | SM | 1, "done before");
    pls(1);
    wt(0, "second start");
    rd(12'h000, ON | 32'h20 | AU, "done by start");
    // Disable last; no access follows in the next cycle
    wr(12'h000, 0);
    final_report;
  end
endmodule : testbench
`default_nettype wire
